/* File: shared/ocg_pkg.sv */
// Package: constants and types of the offset/gain calibration block
package ocg_pkg;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [7:0]  OCG_ADDR_CTRL    = 8'h00;
    localparam logic [7:0]  OCG_ADDR_STATUS  = 8'h04;
    localparam logic [7:0]  OCG_ADDR_OFFSET  = 8'h20;
    localparam logic [7:0]  OCG_ADDR_GAIN    = 8'h40;
    localparam int          OCG_NCH          = 8;
    localparam int          OCG_CTRL_START   = 0;
    localparam int          OCG_CTRL_FUNC    = 1;
    localparam int          OCG_CTRL_CHAN    = 3;
    localparam int          OCG_CTRL_RATE    = 6;
    localparam int          OCG_CTRL_RANGE   = 9;
    localparam int          OCG_STAT_BUSY    = 0;
    localparam int          OCG_STAT_DONE    = 1;

    // ------------------------------------------------------------
    // Correction words
    // ------------------------------------------------------------
    localparam logic [23:0] OCG_GAIN_RESET   = 24'h400000;
    localparam logic [23:0] OCG_OFFSET_RESET = 24'h000000;
    localparam logic [23:0] OCG_GAIN_MAX     = 24'hFFFFFF;
    localparam logic [45:0] OCG_FS_DIVIDEND  = 46'h1FFFFFC00000;
    localparam int          OCG_GAIN_SHIFT   = 22;
    localparam int          OCG_DIV_STEPS    = 46;
    localparam logic [2:0]  OCG_LOW_RANGES   = 3'h3;

    typedef enum logic [1:0] {
        OCG_SELF_OFFSET, OCG_SELF_GAIN, OCG_SYS_OFFSET, OCG_SYS_GAIN
    } ocg_func_t;

    typedef enum logic [1:0] {
        OCG_ROUTE_NORMAL, OCG_ROUTE_AMP_SHORT, OCG_ROUTE_MOD_SHORT,
        OCG_ROUTE_REF
    } ocg_route_t;

endpackage

/* File: shared/ocg_corr_if.sv */
// Interface: raw results and correction words to the correction datapath
`timescale 1ns/1ns
`default_nettype none
interface ocg_corr_if;
    logic        raw_valid;
    logic [23:0] raw_result;
    logic [23:0] offset_correction_value;
    logic [23:0] gain_correction_value;
    logic        corrected_valid;
    logic [23:0] corrected_result;

    modport core (
        output raw_valid, raw_result, offset_correction_value,
        output gain_correction_value,
        input  corrected_valid, corrected_result
    );
    modport engine (
        input  raw_valid, raw_result, offset_correction_value,
        input  gain_correction_value,
        output corrected_valid, corrected_result
    );
endinterface
`default_nettype wire

/* File: logic/ocg_correct.sv */
// Module: applies offset and gain correction to raw results
`timescale 1ns/1ns
`default_nettype none
module ocg_correct
    import ocg_pkg::*;
(
    input  wire logic aclk,
    input  wire logic aresetn,
    ocg_corr_if.engine cif
);
    logic               next_valid;
    logic        [23:0] next_result;
    logic signed [24:0] sum;
    logic signed [49:0] prod;
    logic signed [49:0] scaled;
    logic               valid_q;
    logic        [23:0] result_q;

    // ------------------------------------------------------------
    // Correction arithmetic
    // ------------------------------------------------------------
    always_comb begin
        // Offset signed, gain unsigned
        sum = 25'(signed'(cif.raw_result)) +
              25'(signed'(cif.offset_correction_value));
        prod = 50'(sum) * signed'({26'h0, cif.gain_correction_value});
        scaled = prod >>> OCG_GAIN_SHIFT;
        // Clip rather than wrap: a wrapped sign is worse than a flat top
        if (scaled > 50'sh7FFFFF) begin
            next_result = 24'h7FFFFF;
        end else if (scaled < -50'sh800000) begin
            next_result = 24'h800000;
        end else begin
            next_result = scaled[23:0];
        end
        next_valid = cif.raw_valid;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            valid_q  <= 1'b0;
            result_q <= 24'h000000;
        end else begin
            valid_q  <= next_valid;
            result_q <= next_result;
        end
    end

    assign cif.corrected_valid  = valid_q;
    assign cif.corrected_result = result_q;

    a_corr_latency: assert property (@(posedge aclk) disable iff (!aresetn)
        cif.raw_valid |=> cif.corrected_valid)
        else $error("corrected result not one cycle after raw");
    a_unity_pass: assert property (@(posedge aclk) disable iff (!aresetn)
        cif.raw_valid && cif.gain_correction_value == OCG_GAIN_RESET &&
        cif.offset_correction_value == OCG_OFFSET_RESET
        |=> cif.corrected_result == $past(cif.raw_result))
        else $error("unity correction changed the result");
endmodule
`default_nettype wire

/* File: logic/ocg_calib.sv */
// Module: calibration control, correction words and register slave
`timescale 1ns/1ns
`default_nettype none
module ocg_calib
    import ocg_pkg::*;
#(
    parameter int unsigned CONV_CYCLES_MIN = 1000000
) (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [7:0]  awaddr,
    input  wire logic [2:0]  awprot,
    input  wire logic        awvalid,
    output logic             awready,
    input  wire logic [31:0] wdata,
    input  wire logic [3:0]  wstrb,
    input  wire logic        wvalid,
    output logic             wready,
    output logic [1:0]       bresp,
    output logic             bvalid,
    input  wire logic        bready,
    input  wire logic [7:0]  araddr,
    input  wire logic [2:0]  arprot,
    input  wire logic        arvalid,
    output logic             arready,
    output logic [31:0]      rdata,
    output logic [1:0]       rresp,
    output logic             rvalid,
    input  wire logic        rready,
    input  wire logic        raw_valid,
    input  wire logic [23:0] raw_result,
    input  wire logic [2:0]  raw_channel,
    output logic             corrected_valid,
    output logic [23:0]      corrected_result,
    output logic             data_out_line,
    output logic [1:0]       cal_route,
    output logic [2:0]       word_rate_select,
    output logic [2:0]       gain_range_select
);
    typedef enum logic [1:0] {
        OCG_IDLE, OCG_MEASURE, OCG_DIVIDE, OCG_WRITE
    } ocg_state_t;

    // Kinds: 0 none, 1 control, 2 status, 3 offset, 4 gain
    function automatic logic [5:0] ocg_decode(input logic [7:0] a);
        logic [5:0] d;
        d = 6'h00;
        if (a == OCG_ADDR_CTRL) begin
            d = 6'h08;
        end else if (a == OCG_ADDR_STATUS) begin
            d = 6'h10;
        end else if (a[7:5] == OCG_ADDR_OFFSET[7:5] && a[1:0] == 2'h0) begin
            d = {3'h3, a[4:2]};
        end else if (a[7:5] == OCG_ADDR_GAIN[7:5] && a[1:0] == 2'h0) begin
            d = {3'h4, a[4:2]};
        end
        return d;
    endfunction

    logic [23:0] offset_mem [OCG_NCH];
    logic [23:0] gain_mem   [OCG_NCH];
    logic [23:0] next_offset_mem [OCG_NCH];
    logic [23:0] next_gain_mem   [OCG_NCH];
    ocg_state_t  state, next_state;
    ocg_func_t   cal_func, next_cal_func;
    logic [2:0]  cal_ch, next_cal_ch;
    logic [2:0]  next_word_rate_select, next_gain_range_select;
    logic        done, next_done;
    logic [31:0] cnt, next_cnt;
    logic [31:0] period;
    logic [23:0] meas, next_meas;
    logic [45:0] dvd, next_dvd;
    logic [24:0] rem, next_rem;
    logic [23:0] quo, next_quo;
    logic        ovf, next_ovf;
    logic [23:0] divisor, next_divisor;
    logic [23:0] cal_off_new;
    logic        next_data_out_line;
    logic [1:0]  next_cal_route;
    logic        next_bvalid, next_rvalid;
    logic [1:0]  next_bresp, next_rresp;
    logic [31:0] next_rdata;
    logic [5:0]  wdec, rdec;
    logic        wr_go, rd_go, start;
    logic [24:0] rem_try;
    logic signed [24:0] meas_sum;

    ocg_corr_if cif ();

    // ------------------------------------------------------------
    // Correction datapath
    // ------------------------------------------------------------
    assign cif.raw_valid               = raw_valid;
    assign cif.raw_result              = raw_result;
    assign cif.offset_correction_value = offset_mem[raw_channel];
    assign cif.gain_correction_value   = gain_mem[raw_channel];
    assign corrected_valid             = cif.corrected_valid;
    assign corrected_result            = cif.corrected_result;

    ocg_correct u_correct (
        .aclk    (aclk),
        .aresetn (aresetn),
        .cif     (cif)
    );

    // ------------------------------------------------------------
    // Register slave handshakes
    // ------------------------------------------------------------
    // Address and data are taken together; simpler than buffering
    assign wr_go   = awvalid && wvalid && !bvalid;
    assign awready = wr_go;
    assign wready  = wr_go;
    assign arready = !rvalid;
    assign rd_go   = arvalid && !rvalid;
    assign wdec    = ocg_decode(awaddr);
    assign rdec    = ocg_decode(araddr);
    assign start   = wr_go && wdec[5:3] == 3'h1 && wstrb[0] &&
                     wdata[OCG_CTRL_START] && state == OCG_IDLE;
    // Longer periods at the lower rates, one doubling per select step
    assign period  = CONV_CYCLES_MIN << word_rate_select;
    assign meas_sum = 25'(signed'(meas)) +
                      25'(signed'(offset_mem[cal_ch]));
    assign cal_off_new = 24'(-signed'(meas));
    assign rem_try = {rem[23:0], dvd[45]};

    always_comb begin
        next_bvalid = bvalid && !bready;
        next_bresp  = bresp;
        next_rvalid = rvalid && !rready;
        next_rresp  = rresp;
        next_rdata  = rdata;
        next_word_rate_select  = word_rate_select;
        next_gain_range_select = gain_range_select;
        next_offset_mem = offset_mem;
        next_gain_mem   = gain_mem;
        if (wr_go) begin
            next_bvalid = 1'b1;
            next_bresp  = wdec[5:3] == 3'h0 ? 2'h2 : 2'h0;
            if (wdec[5:3] == 3'h1 && state == OCG_IDLE) begin
                if (wstrb[0]) begin
                    next_word_rate_select[1:0] = wdata[7:6];
                end
                if (wstrb[1]) begin
                    next_word_rate_select[2] = wdata[8];
                    next_gain_range_select =
                        wdata[OCG_CTRL_RANGE +: 3];
                end
            end
            // Saved words may be reloaded at any time
            for (int b = 0; b < 3; b++) begin
                if (wstrb[b] && wdec[5:3] == 3'h3) begin
                    next_offset_mem[wdec[2:0]][b*8 +: 8] = wdata[b*8 +: 8];
                end
                if (wstrb[b] && wdec[5:3] == 3'h4) begin
                    next_gain_mem[wdec[2:0]][b*8 +: 8] = wdata[b*8 +: 8];
                end
            end
        end
        if (rd_go) begin
            next_rvalid = 1'b1;
            next_rresp  = 2'h0;
            case (rdec[5:3])
                3'h1: next_rdata = {20'h0, gain_range_select,
                                    word_rate_select, cal_ch,
                                    cal_func, 1'b0};
                3'h2: next_rdata = {30'h0, done, state != OCG_IDLE};
                3'h3: next_rdata = {8'h00, offset_mem[rdec[2:0]]};
                3'h4: next_rdata = {8'h00, gain_mem[rdec[2:0]]};
                default: begin
                    next_rdata = 32'h00000000;
                    next_rresp = 2'h2;
                end
            endcase
        end
        if (state == OCG_WRITE) begin
            // One word set per channel; a new range overwrites
            if (cal_func == OCG_SELF_OFFSET || cal_func == OCG_SYS_OFFSET)
            begin
                next_offset_mem[cal_ch] = cal_off_new;
            end else begin
                next_gain_mem[cal_ch] = ovf ? OCG_GAIN_MAX : quo;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid <= 1'b0;
            bresp  <= 2'h0;
            rvalid <= 1'b0;
            rresp  <= 2'h0;
            rdata  <= 32'h00000000;
            word_rate_select  <= 3'h0;
            gain_range_select <= 3'h0;
            for (int i = 0; i < OCG_NCH; i++) begin
                offset_mem[i] <= OCG_OFFSET_RESET;
                gain_mem[i]   <= OCG_GAIN_RESET;
            end
        end else begin
            bvalid <= next_bvalid;
            bresp  <= next_bresp;
            rvalid <= next_rvalid;
            rresp  <= next_rresp;
            rdata  <= next_rdata;
            word_rate_select  <= next_word_rate_select;
            gain_range_select <= next_gain_range_select;
            offset_mem <= next_offset_mem;
            gain_mem   <= next_gain_mem;
        end
    end

    // ------------------------------------------------------------
    // Calibration sequencer
    // ------------------------------------------------------------
    always_comb begin
        next_state    = state;
        next_cal_func = cal_func;
        next_cal_ch   = cal_ch;
        next_done     = done;
        next_cnt      = cnt;
        next_meas     = meas;
        next_dvd      = dvd;
        next_rem      = rem;
        next_quo      = quo;
        next_ovf      = ovf;
        next_divisor  = divisor;
        next_data_out_line = data_out_line;
        next_cal_route = OCG_ROUTE_NORMAL;
        case (state)
            OCG_IDLE: begin
                if (start) begin
                    next_cal_func = ocg_func_t'(wdata[OCG_CTRL_FUNC +: 2]);
                    next_cal_ch   = wdata[OCG_CTRL_CHAN +: 3];
                    next_done     = 1'b0;
                    next_cnt      = 32'h0;
                    next_meas     = 24'h000000;
                    next_data_out_line = 1'b1;
                    next_state    = OCG_MEASURE;
                end
            end
            OCG_MEASURE: begin
                if (cal_func == OCG_SELF_OFFSET) begin
                    next_cal_route = gain_range_select < OCG_LOW_RANGES ?
                        OCG_ROUTE_AMP_SHORT : OCG_ROUTE_MOD_SHORT;
                end else if (cal_func == OCG_SELF_GAIN) begin
                    next_cal_route = OCG_ROUTE_REF;
                end
                // System steps take the host's own signal
                if (raw_valid && raw_channel == cal_ch) begin
                    next_meas = raw_result;
                end
                next_cnt = cnt + 32'h1;
                if (cnt == period - 32'h1) begin
                    next_cnt = 32'h0;
                    next_dvd = OCG_FS_DIVIDEND;
                    next_rem = 25'h0;
                    next_quo = 24'h000000;
                    next_cal_route = OCG_ROUTE_NORMAL;
                    // Zero or negative span cannot be divided: saturate
                    next_ovf = meas_sum <= 25'sh0 || meas_sum[24:23] != 2'h0;
                    next_divisor = meas_sum[23:0];
                    next_state = (cal_func == OCG_SELF_GAIN ||
                                  cal_func == OCG_SYS_GAIN) ?
                                 OCG_DIVIDE : OCG_WRITE;
                end
            end
            OCG_DIVIDE: begin
                // Restoring divide, one quotient bit per cycle
                next_cnt = cnt + 32'h1;
                next_dvd = {dvd[44:0], 1'b0};
                next_ovf = ovf || quo[23];
                if (rem_try >= {1'b0, divisor}) begin
                    next_rem = rem_try - {1'b0, divisor};
                    next_quo = {quo[22:0], 1'b1};
                end else begin
                    next_rem = rem_try;
                    next_quo = {quo[22:0], 1'b0};
                end
                if (cnt == 32'(OCG_DIV_STEPS - 1)) begin
                    next_state = OCG_WRITE;
                end
            end
            OCG_WRITE: begin
                next_done  = 1'b1;
                next_data_out_line = 1'b0;
                next_state = OCG_IDLE;
            end
            default: next_state = OCG_IDLE;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state    <= OCG_IDLE;
            cal_func <= OCG_SELF_OFFSET;
            cal_ch   <= 3'h0;
            done     <= 1'b0;
            cnt      <= 32'h0;
            meas     <= 24'h000000;
            dvd      <= 46'h0;
            rem      <= 25'h0;
            quo      <= 24'h000000;
            ovf      <= 1'b0;
            divisor  <= 24'h000000;
            data_out_line <= 1'b0;
            cal_route     <= OCG_ROUTE_NORMAL;
        end else begin
            state    <= next_state;
            cal_func <= next_cal_func;
            cal_ch   <= next_cal_ch;
            done     <= next_done;
            cnt      <= next_cnt;
            meas     <= next_meas;
            dvd      <= next_dvd;
            rem      <= next_rem;
            quo      <= next_quo;
            ovf      <= next_ovf;
            divisor  <= next_divisor;
            data_out_line <= next_data_out_line;
            cal_route     <= next_cal_route;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    a_reset_words: assert property (@(posedge aclk)
        !aresetn |=> gain_mem[0] == OCG_GAIN_RESET &&
        offset_mem[7] == OCG_OFFSET_RESET)
        else $error("reset words wrong");
    a_done_sdo_low: assert property (@(posedge aclk) disable iff (!aresetn)
        state == OCG_WRITE |=> !data_out_line && done)
        else $error("data-out not low after step");
    a_busy_sdo_high: assert property (@(posedge aclk) disable iff (!aresetn)
        state == OCG_MEASURE |-> data_out_line)
        else $error("data-out low during step");
    a_step_bound: assert property (@(posedge aclk) disable iff (!aresetn)
        state == OCG_MEASURE |-> cnt < period)
        else $error("step longer than conversion");
    a_step_end: assert property (@(posedge aclk) disable iff (!aresetn)
        state == OCG_MEASURE && cnt == period - 32'h1
        |=> state != OCG_MEASURE)
        else $error("step did not end at period");
    a_gain_sat: assert property (@(posedge aclk) disable iff (!aresetn)
        state == OCG_WRITE && cal_func == OCG_SYS_GAIN && ovf
        |=> gain_mem[$past(cal_ch)] == OCG_GAIN_MAX)
        else $error("gain not saturated");
    a_offset_store: assert property (@(posedge aclk) disable iff (!aresetn)
        state == OCG_WRITE && cal_func == OCG_SYS_OFFSET
        |=> offset_mem[$past(cal_ch)] == $past(cal_off_new))
        else $error("offset not stored in channel");
    a_route_gain: assert property (@(posedge aclk) disable iff (!aresetn)
        $past(state) == OCG_MEASURE && state == OCG_MEASURE &&
        cal_func == OCG_SELF_GAIN |-> cal_route == OCG_ROUTE_REF)
        else $error("self gain route wrong");
    a_route_offset: assert property (@(posedge aclk) disable iff (!aresetn)
        $past(state) == OCG_MEASURE && state == OCG_MEASURE &&
        cal_func == OCG_SELF_OFFSET && gain_range_select >= OCG_LOW_RANGES
        |-> cal_route == OCG_ROUTE_MOD_SHORT)
        else $error("self offset route wrong");
endmodule
`default_nettype wire

/* File: verification/ocg_host.sv */
// Host model: register access master on the AXI4-Lite port
`timescale 1ns/1ns
`default_nettype none
module ocg_host (
    input  wire logic        aclk,
    output logic [7:0]       awaddr, araddr,
    output logic [2:0]       awprot, arprot,
    output logic             awvalid, wvalid, bready, arvalid, rready,
    output logic [31:0]      wdata,
    output logic [3:0]       wstrb,
    input  wire logic        awready, wready, bvalid, arready, rvalid,
    input  wire logic [1:0]  bresp, rresp,
    input  wire logic [31:0] rdata
);
    int tmo = 0;
    initial begin
        {awaddr, araddr, awprot, arprot} = '0;
        {awvalid, wvalid, bready, arvalid, rready} = '0;
        wdata = '0;
        wstrb = 4'hF;
    end
    // Every wait is bounded; an expiry is counted, never hidden
    task automatic wr(input logic [7:0] a, input logic [31:0] d,
                      output logic [1:0] r);
        int n;
        n = 0;
        @(posedge aclk);
        awaddr  <= a;
        wdata   <= d;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        // Each channel released on its own ready, in either order
        do begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (((awvalid && !awready) || (wvalid && !wready)) &&
                   ++n < 100);
        do @(posedge aclk); while (!bvalid && ++n < 100);
        r = bresp;
        bready <= 1'b0;
        if (n >= 100) tmo++;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d,
                      output logic [1:0] r);
        int n;
        n = 0;
        @(posedge aclk);
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        do @(posedge aclk); while (!arready && ++n < 100);
        arvalid <= 1'b0;
        do @(posedge aclk); while (!rvalid && ++n < 100);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        if (n >= 100) tmo++;
    endtask
endmodule
`default_nettype wire

/* File: verification/adc_offset_gain_calibration_tb.sv */
// Testbench: register access, correction and calibration steps
`timescale 1ns/1ns
`default_nettype none
module adc_offset_gain_calibration_tb;
    import ocg_pkg::*;
    logic        aclk, aresetn, raw_valid, corrected_valid, data_out_line;
    logic        awvalid, awready, wvalid, wready, bvalid, bready;
    logic        arvalid, arready, rvalid, rready;
    logic [2:0]  raw_channel, word_rate_select, gain_range_select;
    logic [2:0]  awprot, arprot;
    logic [7:0]  awaddr, araddr;
    logic [31:0] wdata, rdata, d;
    logic [3:0]  wstrb;
    logic [1:0]  bresp, rresp, cal_route, r;
    logic [23:0] raw_result, corrected_result;
    int          fail_count = 0;
    int          total_checks = 0;
    // Conversion shortened so a step takes tens of cycles
    ocg_calib #(.CONV_CYCLES_MIN(8)) u_dut (.*);
    ocg_host u_host (.*);
    initial begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end
    task automatic chk(input string nm, input logic [31:0] e, g);
        total_checks++;
        if (g !== e) begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic test_done();
        fail_count += u_host.tmo;
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task automatic corr(input logic [2:0] ch, input logic [23:0] raw, e);
        @(posedge aclk);
        raw_valid   <= 1'b1;
        raw_channel <= ch;
        raw_result  <= raw;
        @(posedge aclk);
        raw_valid <= 1'b0;
        #1;
        chk("corrected_valid", 1, corrected_valid);
        chk("corrected_result", e, corrected_result);
    endtask
    task automatic t_reset();
        u_host.rd(OCG_ADDR_GAIN, d, r);
        chk("gain_reset", 32'h400000, d);
        u_host.rd(OCG_ADDR_OFFSET + 8'h1C, d, r);
        chk("offset_reset", 32'h0, d);
        chk("line_reset", 0, data_out_line);
        corr(3'h0, 24'h001234, 24'h001234);
        $display("t_reset done");
    endtask
    task automatic t_words();
        u_host.wr(OCG_ADDR_OFFSET + 8'h08, 32'hFFFFF0, r);
        u_host.wr(OCG_ADDR_GAIN + 8'h08, 32'h600000, r);
        corr(3'h2, 24'h000110, 24'h000180);
        corr(3'h2, 24'hFFFF00, 24'hFFFE68);
        u_host.rd(OCG_ADDR_GAIN + 8'h08, d, r);
        u_host.wr(OCG_ADDR_GAIN + 8'h08, {d[30:0], 1'b0}, r);
        corr(3'h2, 24'h000110, 24'h000300);
        u_host.wr(OCG_ADDR_GAIN + 8'h0C, 32'hFFFFFF, r);
        chk("wr_resp", 2'h0, r);
        u_host.rd(OCG_ADDR_GAIN + 8'h0C, d, r);
        chk("gain_max", 32'hFFFFFF, d);
        u_host.rd(8'h10, d, r);
        chk("unmapped_resp", 2'h2, r);
        $display("t_words done");
    endtask
    task automatic cal(input logic [31:0] c, input logic [1:0] rt,
                       input logic [23:0] m, input logic [7:0] a,
                       input logic [23:0] e);
        int n;
        n = 0;
        u_host.wr(OCG_ADDR_CTRL, c, r);
        #1;
        chk("line_busy", 1, data_out_line);
        chk("route", rt, cal_route);
        chk("rate", c[8:6], word_rate_select);
        chk("range", c[11:9], gain_range_select);
        @(posedge aclk);
        raw_valid   <= 1'b1;
        raw_channel <= c[5:3];
        raw_result  <= m;
        @(posedge aclk);
        raw_valid <= 1'b0;
        while (data_out_line && n < 300) begin
            @(posedge aclk);
            n++;
        end
        if (n >= 300) begin
            fail_count++;
            test_done();
        end
        u_host.rd(a, d, r);
        chk("cal_word", e, d);
        u_host.rd(OCG_ADDR_STATUS, d, r);
        chk("status_done", 32'h2, d);
        u_host.rd(OCG_ADDR_CTRL, d, r);
        chk("ctrl_fields", c & 32'hFFE, d);
    endtask
    task automatic t_cal();
        cal(32'h009, 2'h1, 24'h000020, OCG_ADDR_OFFSET + 8'h04,
            24'hFFFFE0);
        cal(32'h84B, 2'h3, 24'h200020, OCG_ADDR_GAIN + 8'h04,
            24'hFFFFFE);
        // Higher range: modulator inputs shorted instead
        cal(32'hA19, 2'h2, 24'h000005, OCG_ADDR_OFFSET + 8'h0C,
            24'hFFFFFB);
        // System steps: host applies ground, then a quarter of full scale
        cal(32'h015, 2'h0, 24'h000011, OCG_ADDR_OFFSET + 8'h08,
            24'hFFFFEF);
        cal(32'h017, 2'h0, 24'h200010, OCG_ADDR_GAIN + 8'h08,
            24'hFFFFFF);
        u_host.wr(OCG_ADDR_GAIN + 8'h04, 32'h400000, r);
        corr(3'h1, 24'h000120, 24'h000100);
        $display("t_cal done");
    endtask
    initial begin
        aresetn     = 1'b0;
        raw_valid   = 1'b0;
        raw_result  = '0;
        raw_channel = '0;
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        t_reset();
        t_words();
        t_cal();
        test_done();
    end
endmodule
`default_nettype wire
